// *** inc/fiq_ctrl_pkg.sv ***
package fiq_ctrl_pkg;
	// Source count and register address width
	localparam int NSRC = 32;
	localparam int ADDR_W = 12;
	localparam int SRC_IDX_W = 5;
	localparam int PRIO_W = 3;
	localparam int TYPE_W = 2;

	// Register byte offsets
	localparam logic [11:0] SMR_BASE = 12'h000;
	localparam logic [11:0] SVR_BASE = 12'h080;
	localparam logic [11:0] IVR_OFF = 12'h100;
	localparam logic [11:0] FVR_OFF = 12'h104;
	localparam logic [11:0] ISR_OFF = 12'h108;
	localparam logic [11:0] IPR_OFF = 12'h10C;
	localparam logic [11:0] IMR_OFF = 12'h110;
	localparam logic [11:0] CISR_OFF = 12'h114;
	localparam logic [11:0] IECR_OFF = 12'h120;
	localparam logic [11:0] IDCR_OFF = 12'h124;
	localparam logic [11:0] ICCR_OFF = 12'h128;
	localparam logic [11:0] ISCR_OFF = 12'h12C;
	localparam logic [11:0] EOICR_OFF = 12'h130;
	localparam logic [11:0] SPU_OFF = 12'h134;
	localparam logic [11:0] DCR_OFF = 12'h138;
	localparam logic [11:0] FFER_OFF = 12'h140;
	localparam logic [11:0] FFDR_OFF = 12'h144;
	localparam logic [11:0] FFSR_OFF = 12'h148;

	// Source mode fields
	localparam int SMR_PRIO_LSB = 0;
	localparam int SMR_TYPE_LSB = 5;
	localparam int TYPE_EDGE_BIT = 0;
	localparam int TYPE_HIGH_BIT = 1;

	// Debug control and core status bits
	localparam int DCR_PROT_BIT = 0;
	localparam int DCR_GENERAL_MASK_BIT_BIT = 1;
	localparam int CISR_FIQ_BIT = 0;
	localparam int CISR_IRQ_BIT = 1;

	// Sources wired to pins, whose polarity is programmable
	localparam logic [31:0] EXT_SRC_MASK = 32'hE000_0001;

	// Reset values
	localparam logic [31:0] WORD_RST = 32'h0000_0000;
	localparam logic [4:0] SMR_RST = 5'h00;

	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [0:0] {RD_IDLE = 1'b0, RD_DATA = 1'b1} rd_state_t;
	typedef enum logic [0:0] {WR_COLLECT = 1'b0, WR_RESP = 1'b1} wr_state_t;
endpackage

// *** rtl/fast_interrupt_and_debug_control.sv ***
// What this block does
// - Fast path has no arbitration; source 0 priority field stored, never used.
// - Source 0 type selects rising, falling, high or low sensitivity.
// - Enable and disable commands with bit 0 set; mask bit 0 shows state.
// - Fast vector read returns source 0 vector for native or forced requests.
// - Fast vector read clears edge source 0, dropping the fast line only then.
// - Forcing enable and disable writes set and clear forcing status bits.
// - Forced sources keep edge detection but never reach the normal request.
// - Forced source with active level or edge asserts the fast request.
// - Forcing never touches the source 0 pending bit.
// - No vector read clears a forced source; only the clear command does.
// - Source 0 keeps working normally alongside forced sources.
// - Protect mode bit set in debug control makes interrupt vector reads side-effect free; fast vector reads still clear edge source 0.
// - Protect mode read only computes, returns, memorizes; write pushes and acknowledges.
// - Protect mode context and status change only on a normal vector write or an end-of-service write.
// - Normal mode read computes, returns, memorizes, pushes, acknowledges; write ignored.
// - Normal vector read with nothing pending returns the spurious vector.
// - General mask bit forces both request lines inactive.
// - General mask does not block the idle wake-up event.
// - Only source 0 and forced sources can raise the fast request.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
module fast_interrupt_and_debug_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [31:0] src_in,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic normal_req_n,
	output logic fast_req_n,
	output logic wake_evt,
	output logic push_pulse,
	output logic [4:0] push_src,
	output logic [2:0] push_lvl,
	output logic eoi_pulse
);
	localparam int N = fiq_ctrl_pkg::NSRC;

	// Byte-lane merge for stored registers
	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
			input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Highest priority candidate, lowest number wins a tie: {found, level, index}
	function automatic logic [8:0] pick_best(input logic [31:0] cand,
			input logic [N*5-1:0] smr_flat);
		logic found;
		logic [2:0] lvl;
		logic [4:0] idx;
		logic [2:0] p;
		found = 1'b0;
		lvl = 3'h0;
		idx = 5'h00;
		p = 3'h0;
		for (int i = 1; i < N; i++) begin
			p = smr_flat[i*5 + fiq_ctrl_pkg::SMR_PRIO_LSB +: 3];
			if (cand[i] && (!found || p > lvl)) begin
				found = 1'b1;
				lvl = p;
				idx = i[4:0];
			end
		end
		return {found, lvl, idx};
	endfunction

	// Bus state
	fiq_ctrl_pkg::rd_state_t rd_state_q, rd_state_d;
	fiq_ctrl_pkg::wr_state_t wr_state_q, wr_state_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d;
	logic [11:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d, bresp_q, bresp_d;

	// Configuration state
	logic [4:0] smr_q [N], smr_d [N];
	logic [31:0] svr_q [N], svr_d [N];
	logic [N*5-1:0] smr_flat;
	logic [31:0] spu_q, spu_d, en_q, en_d, force_q, force_d;
	logic prot_q, prot_d, general_mask_bit_q, general_mask_bit_d;

	// Source state
	logic [31:0] latch_q, latch_d, act_prev_q, act_prev_d;
	logic [31:0] act_now, is_edge, pend, clr_by_read;

	// Context state
	logic cur_valid_q, cur_valid_d, memo_valid_q, memo_valid_d;
	logic [4:0] cur_src_q, cur_src_d, memo_src_q, memo_src_d;
	logic [2:0] cur_lvl_q, cur_lvl_d, memo_lvl_q, memo_lvl_d;
	logic push_q, push_d, eoi_q, eoi_d;
	logic [4:0] push_src_q, push_src_d;
	logic [2:0] push_lvl_q, push_lvl_d;

	// Decoded accesses
	logic rd_fire, wr_fire;
	logic [11:0] wa, ra;
	logic [31:0] wd, cmd;
	logic [3:0] ws;
	logic ivr_rd, fvr_rd, ivr_wr;
	logic [8:0] best;
	logic irq_ok, fiq_raw, irq_raw;

	// Handshakes are combinational, data and responses from flip-flops
	assign s_axi_arready = (rd_state_q == fiq_ctrl_pkg::RD_IDLE);
	assign s_axi_awready = (wr_state_q == fiq_ctrl_pkg::WR_COLLECT) && !aw_got_q;
	assign s_axi_wready = (wr_state_q == fiq_ctrl_pkg::WR_COLLECT) && !w_got_q;
	assign s_axi_rvalid = (rd_state_q == fiq_ctrl_pkg::RD_DATA);
	assign s_axi_bvalid = (wr_state_q == fiq_ctrl_pkg::WR_RESP);
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_bresp = bresp_q;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wr_fire = (wr_state_q == fiq_ctrl_pkg::WR_COLLECT) &&
		(aw_got_q || s_axi_awvalid) && (w_got_q || s_axi_wvalid);
	assign wa = aw_got_q ? awaddr_q : s_axi_awaddr;
	assign wd = w_got_q ? wdata_q : s_axi_wdata;
	assign ws = w_got_q ? wstrb_q : s_axi_wstrb;
	assign cmd = wd & {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
	assign ra = s_axi_araddr;
	assign ivr_rd = rd_fire && (ra == fiq_ctrl_pkg::IVR_OFF);
	assign fvr_rd = rd_fire && (ra == fiq_ctrl_pkg::FVR_OFF);
	assign ivr_wr = wr_fire && (wa == fiq_ctrl_pkg::IVR_OFF);

	// Source sensing; pin sources may be inverted, internal ones are fixed active high
	always_comb begin
		for (int i = 0; i < N; i++) begin
			smr_flat[i*5 +: 5] = smr_q[i];
			// Stored mode packs type above the three priority bits, two gaps closed
			is_edge[i] = smr_q[i][fiq_ctrl_pkg::SMR_TYPE_LSB - 2 + fiq_ctrl_pkg::TYPE_EDGE_BIT];
			act_now[i] = src_in[i] ^ (fiq_ctrl_pkg::EXT_SRC_MASK[i] &&
				!smr_q[i][fiq_ctrl_pkg::SMR_TYPE_LSB - 2 + fiq_ctrl_pkg::TYPE_HIGH_BIT]);
		end
		// Level sources pend while active; edge sources hold a latch
		pend = (is_edge & latch_q) | (~is_edge & act_now);
	end

	// Request lines and wake-up
	always_comb begin
		best = pick_best(pend & en_q & ~force_q, smr_flat);
		irq_ok = best[8] && (!cur_valid_q || best[7:5] > cur_lvl_q);
		// No level comparison here: any enabled fast candidate fires
		fiq_raw = (pend[0] && en_q[0]) || |(pend[N-1:1] & en_q[N-1:1] & force_q[N-1:1]);
		irq_raw = irq_ok;
		normal_req_n = !(irq_raw && !general_mask_bit_q);
		fast_req_n = !(fiq_raw && !general_mask_bit_q);
		wake_evt = |(pend & en_q);
	end

	// Edge clears caused by vector reads and acknowledges
	always_comb begin
		clr_by_read = '0;
		// Source 0 can never be forced, so only its own edge latch is cleared
		if (fvr_rd && is_edge[0]) begin
			clr_by_read[0] = 1'b1;
		end
		if (ivr_rd && !prot_q && irq_ok) begin
			clr_by_read[best[4:0]] = 1'b1;
		end
		if (ivr_wr && prot_q && memo_valid_q) begin
			clr_by_read[memo_src_q] = 1'b1;
		end
		// Forced sources are cleared only through the clear command
		clr_by_read = clr_by_read & ~(force_q & {{(N-1){1'b1}}, 1'b0});
	end

	// Source latches; a new edge wins over any clear in the same cycle
	always_comb begin
		act_prev_d = act_now;
		latch_d = latch_q & ~clr_by_read;
		if (wr_fire && wa == fiq_ctrl_pkg::ICCR_OFF) begin
			latch_d = latch_d & ~cmd;
		end
		if (wr_fire && wa == fiq_ctrl_pkg::ISCR_OFF) begin
			latch_d = latch_d | (cmd & is_edge);
		end
		latch_d = (latch_d | (act_now & ~act_prev_q)) & is_edge;
	end

	// Configuration registers
	always_comb begin
		smr_d = smr_q;
		svr_d = svr_q;
		spu_d = spu_q;
		en_d = en_q;
		force_d = force_q;
		prot_d = prot_q;
		general_mask_bit_d = general_mask_bit_q;
		// Unaligned writes answer an error and must leave the tables alone
		if (wr_fire && wa[1:0] == 2'b00) begin
			if (wa < fiq_ctrl_pkg::SVR_BASE) begin
				// Priority of source 0 is kept for readback only
				smr_d[wa[6:2]] = {cmd[fiq_ctrl_pkg::SMR_TYPE_LSB +: 2],
					cmd[fiq_ctrl_pkg::SMR_PRIO_LSB +: 3]} |
					(smr_q[wa[6:2]] & {{2{!ws[0]}}, {3{!ws[0]}}});
			end else if (wa < fiq_ctrl_pkg::IVR_OFF) begin
				svr_d[wa[6:2]] = strb_merge(svr_q[wa[6:2]], wd, ws);
			end
			unique case (wa)
				fiq_ctrl_pkg::IECR_OFF: en_d = en_q | cmd;
				fiq_ctrl_pkg::IDCR_OFF: en_d = en_q & ~cmd;
				fiq_ctrl_pkg::SPU_OFF: spu_d = strb_merge(spu_q, wd, ws);
				fiq_ctrl_pkg::DCR_OFF: begin
					if (ws[0]) begin
						prot_d = wd[fiq_ctrl_pkg::DCR_PROT_BIT];
						general_mask_bit_d = wd[fiq_ctrl_pkg::DCR_GENERAL_MASK_BIT_BIT];
					end
				end
				// Source 0 is already fast, so its forcing bit stays clear
				fiq_ctrl_pkg::FFER_OFF: force_d = force_q | (cmd & 32'hFFFF_FFFE);
				fiq_ctrl_pkg::FFDR_OFF: force_d = force_q & ~cmd;
				default: ;
			endcase
		end
	end

	// Current interrupt context and the stack-push and end-of-service pulses
	always_comb begin
		cur_valid_d = cur_valid_q;
		cur_src_d = cur_src_q;
		cur_lvl_d = cur_lvl_q;
		memo_valid_d = memo_valid_q;
		memo_src_d = memo_src_q;
		memo_lvl_d = memo_lvl_q;
		push_d = 1'b0;
		push_src_d = push_src_q;
		push_lvl_d = push_lvl_q;
		eoi_d = 1'b0;
		if (ivr_rd) begin
			memo_valid_d = irq_ok;
			memo_src_d = best[4:0];
			memo_lvl_d = best[7:5];
			if (!prot_q && irq_ok) begin
				// Old level leaves on the push port, new one becomes current
				push_d = 1'b1;
				push_src_d = cur_src_q;
				push_lvl_d = cur_lvl_q;
				cur_valid_d = 1'b1;
				cur_src_d = best[4:0];
				cur_lvl_d = best[7:5];
			end
		end
		// Write in normal mode is ignored; in protect mode it commits the memo
		if (ivr_wr && prot_q && memo_valid_q) begin
			push_d = 1'b1;
			push_src_d = cur_src_q;
			push_lvl_d = cur_lvl_q;
			cur_valid_d = 1'b1;
			cur_src_d = memo_src_q;
			cur_lvl_d = memo_lvl_q;
			memo_valid_d = 1'b0;
		end
		if (wr_fire && wa == fiq_ctrl_pkg::EOICR_OFF) begin
			eoi_d = 1'b1;
			cur_valid_d = 1'b0;
			cur_src_d = 5'h00;
			cur_lvl_d = 3'h0;
		end
	end

	// Bus channels and read data
	always_comb begin
		rd_state_d = rd_state_q;
		wr_state_d = wr_state_q;
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		bresp_d = bresp_q;
		unique case (wr_state_q)
			fiq_ctrl_pkg::WR_COLLECT: begin
				if (wr_fire) begin
					wr_state_d = fiq_ctrl_pkg::WR_RESP;
					aw_got_d = 1'b0;
					w_got_d = 1'b0;
					// Read-only and reserved words refuse writes
					bresp_d = (wa[1:0] != 2'b00 || wa > fiq_ctrl_pkg::FFDR_OFF ||
						(wa > fiq_ctrl_pkg::IVR_OFF && wa < fiq_ctrl_pkg::IECR_OFF) ||
						wa == 12'h13C) ? fiq_ctrl_pkg::RESP_SLVERR :
						fiq_ctrl_pkg::RESP_OKAY;
				end else begin
					if (s_axi_awvalid && s_axi_awready) begin
						aw_got_d = 1'b1;
						awaddr_d = s_axi_awaddr;
					end
					if (s_axi_wvalid && s_axi_wready) begin
						w_got_d = 1'b1;
						wdata_d = s_axi_wdata;
						wstrb_d = s_axi_wstrb;
					end
				end
			end
			fiq_ctrl_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					wr_state_d = fiq_ctrl_pkg::WR_COLLECT;
				end
			end
		endcase
		unique case (rd_state_q)
			fiq_ctrl_pkg::RD_IDLE: begin
				if (rd_fire) begin
					rd_state_d = fiq_ctrl_pkg::RD_DATA;
					rresp_d = fiq_ctrl_pkg::RESP_OKAY;
					rdata_d = fiq_ctrl_pkg::WORD_RST;
					if (ra[1:0] != 2'b00) begin
						rresp_d = fiq_ctrl_pkg::RESP_SLVERR;
					end else if (ra < fiq_ctrl_pkg::SVR_BASE) begin
						rdata_d = {25'h000_0000, smr_q[ra[6:2]][4:3], 2'b00,
							smr_q[ra[6:2]][2:0]};
					end else if (ra < fiq_ctrl_pkg::IVR_OFF) begin
						rdata_d = svr_q[ra[6:2]];
					end else begin
						unique case (ra)
							fiq_ctrl_pkg::IVR_OFF: rdata_d = irq_ok ?
								svr_q[best[4:0]] : spu_q;
							fiq_ctrl_pkg::FVR_OFF: rdata_d = fiq_raw ?
								svr_q[0] : spu_q;
							fiq_ctrl_pkg::ISR_OFF: rdata_d = {27'h000_0000, cur_src_q};
							fiq_ctrl_pkg::IPR_OFF: rdata_d = pend;
							fiq_ctrl_pkg::IMR_OFF: rdata_d = en_q;
							fiq_ctrl_pkg::CISR_OFF: rdata_d = {30'h0000_0000,
								!normal_req_n, !fast_req_n};
							fiq_ctrl_pkg::SPU_OFF: rdata_d = spu_q;
							fiq_ctrl_pkg::DCR_OFF: rdata_d = {30'h0000_0000, general_mask_bit_q, prot_q};
							fiq_ctrl_pkg::FFSR_OFF: rdata_d = force_q;
							fiq_ctrl_pkg::IECR_OFF, fiq_ctrl_pkg::IDCR_OFF,
							fiq_ctrl_pkg::ICCR_OFF, fiq_ctrl_pkg::ISCR_OFF,
							fiq_ctrl_pkg::EOICR_OFF, fiq_ctrl_pkg::FFER_OFF,
							fiq_ctrl_pkg::FFDR_OFF: rdata_d = fiq_ctrl_pkg::WORD_RST;
							default: rresp_d = fiq_ctrl_pkg::RESP_SLVERR;
						endcase
					end
				end
			end
			fiq_ctrl_pkg::RD_DATA: begin
				if (s_axi_rready) begin
					rd_state_d = fiq_ctrl_pkg::RD_IDLE;
				end
			end
		endcase
	end

	// Registers; clock enable low freezes everything
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_state_q <= fiq_ctrl_pkg::RD_IDLE;
			wr_state_q <= fiq_ctrl_pkg::WR_COLLECT;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 12'h000;
			wdata_q <= fiq_ctrl_pkg::WORD_RST;
			wstrb_q <= 4'h0;
			rdata_q <= fiq_ctrl_pkg::WORD_RST;
			rresp_q <= fiq_ctrl_pkg::RESP_OKAY;
			bresp_q <= fiq_ctrl_pkg::RESP_OKAY;
			for (int i = 0; i < N; i++) begin
				smr_q[i] <= fiq_ctrl_pkg::SMR_RST;
				svr_q[i] <= fiq_ctrl_pkg::WORD_RST;
			end
			spu_q <= fiq_ctrl_pkg::WORD_RST;
			en_q <= fiq_ctrl_pkg::WORD_RST;
			force_q <= fiq_ctrl_pkg::WORD_RST;
			prot_q <= 1'b0;
			general_mask_bit_q <= 1'b0;
			latch_q <= fiq_ctrl_pkg::WORD_RST;
			act_prev_q <= fiq_ctrl_pkg::WORD_RST;
			cur_valid_q <= 1'b0;
			cur_src_q <= 5'h00;
			cur_lvl_q <= 3'h0;
			memo_valid_q <= 1'b0;
			memo_src_q <= 5'h00;
			memo_lvl_q <= 3'h0;
			push_q <= 1'b0;
			push_src_q <= 5'h00;
			push_lvl_q <= 3'h0;
			eoi_q <= 1'b0;
		end else if (ce) begin
			rd_state_q <= rd_state_d;
			wr_state_q <= wr_state_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
			bresp_q <= bresp_d;
			smr_q <= smr_d;
			svr_q <= svr_d;
			spu_q <= spu_d;
			en_q <= en_d;
			force_q <= force_d;
			prot_q <= prot_d;
			general_mask_bit_q <= general_mask_bit_d;
			latch_q <= latch_d;
			act_prev_q <= act_prev_d;
			cur_valid_q <= cur_valid_d;
			cur_src_q <= cur_src_d;
			cur_lvl_q <= cur_lvl_d;
			memo_valid_q <= memo_valid_d;
			memo_src_q <= memo_src_d;
			memo_lvl_q <= memo_lvl_d;
			push_q <= push_d;
			push_src_q <= push_src_d;
			push_lvl_q <= push_lvl_d;
			eoi_q <= eoi_d;
		end
	end

	assign push_pulse = push_q;
	assign push_src = push_src_q;
	assign push_lvl = push_lvl_q;
	assign eoi_pulse = eoi_q;
endmodule

// *** verif/fiq_ctrl_properties.sv ***
module fiq_ctrl_checker (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic normal_req_n,
	input wire logic wake_evt,
	input wire logic push_pulse,
	input wire logic eoi_pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	// One clock domain, so clock and reset are given once
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Transfer steps on the register bus
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && ce;
	endsequence
	sequence s_rd_take;
		s_axi_arvalid && s_axi_arready && ce;
	endsequence

	a_write_answer: assert property (s_wr_take |=> s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
		else $error("read data late");
	a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before accepted");
	a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before accepted");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	// Acknowledge only as part of a vector access answer
	a_push_on_access: assert property (push_pulse |-> s_axi_rvalid || s_axi_bvalid)
		else $error("push without a vector access");
	a_push_single: assert property (push_pulse |=> !push_pulse)
		else $error("push lasted more than one cycle");
	a_eoi_pulse_once: assert property (eoi_pulse |-> s_axi_bvalid ##1 !eoi_pulse)
		else $error("end of service pulse misplaced");
	// Wake event ignores the general mask, so a live request implies it
	a_normal_wakes: assert property (!normal_req_n |-> wake_evt)
		else $error("normal request without wake event");
	a_reset_clean: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !push_pulse && !eoi_pulse)
		else $error("state not cleared by reset");
endmodule

bind fast_interrupt_and_debug_control fiq_ctrl_checker u_fiq_ctrl_checker (
	.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .normal_req_n(normal_req_n),
	.wake_evt(wake_evt), .push_pulse(push_pulse), .eoi_pulse(eoi_pulse)
);

// *** verif/core_req_model.sv ***
module core_req_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic fast_req_n,
	output logic [7:0] fast_entries,
	output logic [31:0] pc_q
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] FAST_VEC = 32'h0000_001C;
	logic fast_prev_q;
	// Core enters the fast exception on each falling request edge
	always @(posedge aclk) begin
		if (!aresetn) begin
			fast_entries <= 8'h00;
			pc_q <= 32'h0000_0000;
			fast_prev_q <= 1'b1;
		end else begin
			fast_prev_q <= fast_req_n;
			if (!fast_req_n && fast_prev_q) begin
				fast_entries <= fast_entries + 8'h01;
				pc_q <= FAST_VEC;
			end
		end
	end
endmodule

// *** verif/testbench.sv ***
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic normal_req_n, fast_req_n, wake_evt, push_pulse, eoi_pulse;
	logic [31:0] src_in, s_axi_wdata, s_axi_rdata, rd_data, pc_q;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
	logic [4:0] push_src;
	logic [2:0] push_lvl;
	logic [7:0] fast_entries;
	int err_count, num_checks, push_cnt, eoi_cnt, cyc, p0;
	logic [11:0] rst_regs[6] = '{fiq_ctrl_pkg::SMR_BASE, fiq_ctrl_pkg::SVR_BASE,
		fiq_ctrl_pkg::IMR_OFF, fiq_ctrl_pkg::FFSR_OFF, fiq_ctrl_pkg::DCR_OFF, fiq_ctrl_pkg::SPU_OFF};

	fast_interrupt_and_debug_control u_fast_interrupt_and_debug_control (.*);
	core_req_model u_core_req_model (.aclk(aclk), .aresetn(aresetn), .fast_req_n(fast_req_n),
		.fast_entries(fast_entries), .pc_q(pc_q));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// Pulse counters and hang guard; ceiling is about sixteen times the expected run
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (push_pulse === 1'b1) push_cnt <= push_cnt + 1;
		if (eoi_pulse === 1'b1) eoi_cnt <= eoi_cnt + 1;
		if (cyc == 5000) begin
			err_count++;
			$display("FAIL %0t: timeout", $time);
			results();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic chkb(input logic seen, input logic exp);
		chk({31'h0, seen}, {31'h0, exp});
	endtask

	// Settle after n edges so combinational outputs are read stable
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
		@(negedge aclk);
	endtask

	// Handshakes are judged mid-cycle, acted on at the next rising edge
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tb = s_axi_bvalid & s_axi_bready;
			wr_resp = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a);
		logic ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid & s_axi_arready;
			tr = s_axi_rvalid & s_axi_rready;
			rd_data = s_axi_rdata;
			rd_resp = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
	endtask

	task automatic wc(input logic [11:0] a, input logic [31:0] d);
		wr(a, d);
		chk({30'h0, wr_resp}, {30'h0, fiq_ctrl_pkg::RESP_OKAY});
	endtask

	task automatic rc(input logic [11:0] a, input logic [31:0] exp);
		rd(a);
		chk({30'h0, rd_resp}, {30'h0, fiq_ctrl_pkg::RESP_OKAY});
		chk(rd_data, exp);
	endtask

	task automatic sset(input int i, input logic v);
		@(posedge aclk);
		src_in[i] <= v;
	endtask

	task automatic results;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
		{err_count, num_checks, push_cnt, eoi_cnt, cyc} = 160'h0;
		ce = 1'b1;
		s_axi_wstrb = 4'hF;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
		src_in = fiq_ctrl_pkg::EXT_SRC_MASK; // Pins idle high, internal idle low
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		wt(1);
		chkb(fast_req_n, 1'b1);
		chkb(normal_req_n, 1'b1);
		foreach (rst_regs[i]) rc(rst_regs[i], 32'h0000_0000);
		rd(12'h13C);
		chk({30'h0, rd_resp}, {30'h0, fiq_ctrl_pkg::RESP_SLVERR});
		wr(fiq_ctrl_pkg::IPR_OFF, 32'h0000_0001);
		chk({30'h0, wr_resp}, {30'h0, fiq_ctrl_pkg::RESP_SLVERR});
		$display("reset test done");
		wc(fiq_ctrl_pkg::SVR_BASE, 32'hA0A0_1000);
		wc(fiq_ctrl_pkg::SPU_OFF, 32'h5BAD_0000);
		wc(fiq_ctrl_pkg::SMR_BASE, 32'h0000_0027);
		rc(fiq_ctrl_pkg::SMR_BASE, 32'h0000_0027);
		// Each sensitivity; disabled while retyping so no stray edge fires
		for (int t = 0; t < 4; t++) begin
			wc(fiq_ctrl_pkg::IDCR_OFF, 32'h0000_0001);
			rc(fiq_ctrl_pkg::IMR_OFF, 32'h0000_0000);
			sset(0, !t[1]);
			wc(fiq_ctrl_pkg::SMR_BASE, {25'h0, t[1:0], 5'h00});
			wc(fiq_ctrl_pkg::ICCR_OFF, 32'h0000_0001);
			wc(fiq_ctrl_pkg::IECR_OFF, 32'h0000_0001);
			rc(fiq_ctrl_pkg::IMR_OFF, 32'h0000_0001);
			wt(2);
			chkb(fast_req_n, 1'b1);
			sset(0, t[1]);
			wt(3);
			chkb(fast_req_n, 1'b0);
			rc(fiq_ctrl_pkg::FVR_OFF, 32'hA0A0_1000);
			wt(2);
			chkb(fast_req_n, t[0]);
			sset(0, !t[1]);
			wt(2);
			chkb(fast_req_n, 1'b1);
		end
		chk({24'h0, fast_entries}, 32'h0000_0004);
		chk(pc_q, 32'h0000_001C);
		$display("fast source test done");
		wc(fiq_ctrl_pkg::SMR_BASE + 12'h014, 32'h0000_0020);
		wc(fiq_ctrl_pkg::IECR_OFF, 32'h0000_0020);
		wc(fiq_ctrl_pkg::FFER_OFF, 32'h0000_0020);
		rc(fiq_ctrl_pkg::FFSR_OFF, 32'h0000_0020);
		sset(5, 1'b1);
		wt(3);
		chkb(fast_req_n, 1'b0);
		chkb(normal_req_n, 1'b1);
		rd(fiq_ctrl_pkg::IPR_OFF);
		chk(rd_data & 32'h0000_0021, 32'h0000_0020);
		rc(fiq_ctrl_pkg::FVR_OFF, 32'hA0A0_1000);
		rc(fiq_ctrl_pkg::IVR_OFF, 32'h5BAD_0000);
		wt(1);
		chkb(fast_req_n, 1'b0);
		wc(fiq_ctrl_pkg::ICCR_OFF, 32'h0000_0020);
		wt(1);
		chkb(fast_req_n, 1'b1);
		sset(0, 1'b1);
		wt(3);
		chkb(fast_req_n, 1'b0);
		rc(fiq_ctrl_pkg::FVR_OFF, 32'hA0A0_1000);
		wt(2);
		chkb(fast_req_n, 1'b1);
		wc(fiq_ctrl_pkg::FFDR_OFF, 32'h0000_0020);
		rc(fiq_ctrl_pkg::FFSR_OFF, 32'h0000_0000);
		sset(5, 1'b0);
		$display("forcing test done");
		wc(fiq_ctrl_pkg::SMR_BASE + 12'h01C, 32'h0000_0003);
		wc(fiq_ctrl_pkg::SVR_BASE + 12'h01C, 32'h7777_0000);
		wc(fiq_ctrl_pkg::IECR_OFF, 32'h0000_0080);
		sset(7, 1'b1);
		wt(2);
		chkb(normal_req_n, 1'b0);
		wc(fiq_ctrl_pkg::DCR_OFF, 32'h0000_0001);
		p0 = push_cnt;
		rc(fiq_ctrl_pkg::IVR_OFF, 32'h7777_0000);
		rc(fiq_ctrl_pkg::IVR_OFF, 32'h7777_0000);
		rc(fiq_ctrl_pkg::ISR_OFF, 32'h0000_0000);
		wt(1);
		chk(push_cnt, p0);
		wc(fiq_ctrl_pkg::IVR_OFF, 32'h0000_0000);
		rc(fiq_ctrl_pkg::ISR_OFF, 32'h0000_0007);
		chk(push_cnt, p0 + 1);
		wc(fiq_ctrl_pkg::EOICR_OFF, 32'h0000_0000);
		wc(fiq_ctrl_pkg::DCR_OFF, 32'h0000_0000);
		rc(fiq_ctrl_pkg::IVR_OFF, 32'h7777_0000);
		rc(fiq_ctrl_pkg::ISR_OFF, 32'h0000_0007);
		wc(fiq_ctrl_pkg::IVR_OFF, 32'h0000_0000);
		wt(1);
		chk(push_cnt, p0 + 2);
		wc(fiq_ctrl_pkg::EOICR_OFF, 32'h0000_0000);
		sset(7, 1'b0);
		rc(fiq_ctrl_pkg::IVR_OFF, 32'h5BAD_0000);
		wc(fiq_ctrl_pkg::EOICR_OFF, 32'h0000_0000);
		wt(1);
		chk(eoi_cnt, 3);
		$display("vector test done");
		sset(7, 1'b1);
		wc(fiq_ctrl_pkg::SMR_BASE, 32'h0000_0040);
		wt(1);
		chkb(fast_req_n, 1'b0);
		wc(fiq_ctrl_pkg::DCR_OFF, 32'h0000_0002);
		wt(1);
		chkb(normal_req_n, 1'b1);
		chkb(fast_req_n, 1'b1);
		chkb(wake_evt, 1'b1);
		wc(fiq_ctrl_pkg::DCR_OFF, 32'h0000_0000);
		wt(1);
		chkb(normal_req_n, 1'b0);
		$display("mask test done");
		// Enable low must hold off the edge on source 5 until it returns
		sset(7, 1'b0);
		ce <= 1'b0;
		sset(5, 1'b1);
		wt(3);
		chkb(normal_req_n, 1'b1);
		@(posedge aclk);
		ce <= 1'b1;
		wt(2);
		chkb(normal_req_n, 1'b0);
		$display("enable test done");
		results();
	end
endmodule
